// File: rtl/gal_i2c_slave.sv
`timescale 1ns/1ps
module gal_i2c_slave
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output      logic               sda_oe,
  output      gal_pkg::gal_regbus_t bus,
  output      logic [7:0]         rd_addr,
  input  wire logic [15:0]        rd_data
);

  gal_pkg::gal_i2c_t s;
  gal_pkg::gal_i2c_t next_s;
  logic scl;
  logic sda;
  logic start;
  logic stop;
  logic rise;
  logic fall;

  assign scl     = s.scl_sync[1];
  assign sda     = s.sda_sync[1];
  assign start   = scl && s.scl_d && s.sda_d && !sda;
  assign stop    = scl && s.scl_d && !s.sda_d && sda;
  assign rise    = scl && !s.scl_d;
  assign fall    = !scl && s.scl_d;
  assign sda_oe  = s.oe;
  assign bus     = s.bus;
  assign rd_addr = s.ptr;

  // =====================================================
  // protocol engine
  always_comb
  begin
    next_s          = s;
    next_s.scl_sync = {s.scl_sync[0], scl_in};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.scl_d    = scl;
    next_s.sda_d    = sda;
    next_s.bus.wr   = 1'b0;
    if (start)
    begin
      next_s.st     = gal_pkg::I_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.oe     = 1'b0;
    end
    else if (stop)
    begin
      next_s.st = gal_pkg::I_IDLE;
      next_s.oe = 1'b0;
    end
    else
    begin
      unique case (s.st)
        gal_pkg::I_IDLE: ;
        gal_pkg::I_ADDR, gal_pkg::I_PTR, gal_pkg::I_WR:
        begin
          if (rise)
          begin
            next_s.sh     = {s.sh[6:0], sda};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
          else if (fall && s.bitcnt == gal_pkg::BYTE_BITS)
          begin
            next_s.bitcnt = 4'h0;
            next_s.oe     = 1'b1;
            if (s.st == gal_pkg::I_ADDR)
            begin
              next_s.rw = s.sh[0];
              next_s.st = gal_pkg::I_ACKA;
              if (s.sh[7:1] != gal_pkg::DEV_ADDR)
              begin
                next_s.st = gal_pkg::I_IDLE;
                next_s.oe = 1'b0;
              end
            end
            else if (s.st == gal_pkg::I_PTR)
            begin
              next_s.ptr = s.sh;
              next_s.hi  = 1'b0;
              next_s.st  = gal_pkg::I_ACKP;
            end
            else
            begin
              // low byte first, word written on its high byte
              next_s.hi = !s.hi;
              next_s.st = gal_pkg::I_ACKP;
              if (!s.hi)
                next_s.lo = s.sh;
              else
              begin
                next_s.bus = '{1'b1, s.ptr, {s.sh, s.lo}};
                next_s.ptr = s.ptr + 8'h01;
              end
            end
          end
        end
        gal_pkg::I_ACKA, gal_pkg::I_ACKP:
        begin
          if (fall)
          begin
            next_s.oe     = 1'b0;
            next_s.bitcnt = 4'h0;
            if (s.st == gal_pkg::I_ACKP)
              next_s.st = gal_pkg::I_WR;
            else if (!s.rw)
              next_s.st = gal_pkg::I_PTR;
            else
            begin
              next_s.tx     = rd_data;
              next_s.sh     = rd_data[7:0];
              next_s.hi     = 1'b0;
              next_s.oe     = !rd_data[7];
              next_s.bitcnt = 4'h1;
              next_s.st     = gal_pkg::I_RD;
            end
          end
        end
        gal_pkg::I_RD:
        begin
          if (fall)
          begin
            if (s.bitcnt == gal_pkg::BYTE_BITS)
            begin
              next_s.oe = 1'b0;
              next_s.st = gal_pkg::I_ACKR;
            end
            else
            begin
              next_s.sh     = {s.sh[6:0], 1'b0};
              next_s.oe     = !s.sh[6];
              next_s.bitcnt = s.bitcnt + 4'h1;
            end
          end
        end
        gal_pkg::I_ACKR:
        begin
          if (rise)
            next_s.nack = sda;
          else if (fall)
          begin
            next_s.bitcnt = 4'h1;
            next_s.st     = gal_pkg::I_RD;
            if (s.nack)
              next_s.st = gal_pkg::I_IDLE;
            else if (!s.hi)
            begin
              next_s.sh  = s.tx[15:8];
              next_s.oe  = !s.tx[15];
              next_s.hi  = 1'b1;
              next_s.ptr = s.ptr + 8'h01;
            end
            else
            begin
              next_s.tx = rd_data;
              next_s.sh = rd_data[7:0];
              next_s.oe = !rd_data[7];
              next_s.hi = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s          <= '0;
      s.scl_sync <= 2'b11;
      s.sda_sync <= 2'b11;
      s.scl_d    <= 1'b1;
      s.sda_d    <= 1'b1;
    end
    else
      s <= next_s;
  end

endmodule

// File: rtl/gal_pkg.sv
package gal_pkg;

  // =====================================================
  // register addresses
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] CFG_ADDR    = 8'h1d;
  localparam logic [7:0] TERM_ADDR   = 8'h1e;
  localparam logic [7:0] FWVER_ADDR  = 8'h21;
  localparam logic [7:0] CAPTAB_ADDR = 8'h22;
  localparam logic [7:0] FULL_ADDR   = 8'h23;
  localparam logic [7:0] NOM_ADDR    = 8'h24;
  localparam logic [7:0] LIM_ADDR    = 8'h25;

  // =====================================================
  // field positions
  localparam int CFG_FORCE_BIT = 3;
  localparam int CFG_THR_BIT   = 2;
  localparam int CFG_INS_BIT   = 1;
  localparam int CFG_REM_BIT   = 0;
  localparam int ST_INS_BIT    = 6;
  localparam int ST_REM_BIT    = 7;
  localparam int NOM_LSB       = 6;
  localparam int NOM_W         = 10;
  localparam int LIM_W         = 8;
  localparam int THR_N         = 6;

  // =====================================================
  // constants
  localparam logic [6:0]  DEV_ADDR      = 7'h36;
  // arbitrary value
  localparam logic [15:0] FW_VERSION    = 16'h0a5c;
  localparam logic [15:0] TERM_DIVISOR  = 16'h000a;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [5:0]  NOM_SPARE     = 6'h00;
  localparam logic [7:0]  LIM_FRAC      = 8'h00;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  // =====================================================
  // types
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } gal_regbus_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_ACKA = 3'b010,
    I_PTR  = 3'b011,
    I_ACKP = 3'b100,
    I_WR   = 3'b101,
    I_RD   = 3'b110,
    I_ACKR = 3'b111
  } gal_i2c_st_t;

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_d;
    logic        sda_d;
    gal_i2c_st_t st;
    logic [3:0]  bitcnt;
    logic [7:0]  sh;
    logic        rw;
    logic        nack;
    logic        hi;
    logic [7:0]  ptr;
    logic [7:0]  lo;
    logic [15:0] tx;
    logic        oe;
    gal_regbus_t bus;
  } gal_i2c_t;

  typedef struct packed {
    logic              force_bias;
    logic              thr_en;
    logic              ins_en;
    logic              rem_en;
    logic [15:0]       term_cur;
    logic [15:0]       cap_tab;
    logic [15:0]       full_cap;
    logic [NOM_W-1:0]  nom_temp;
    logic [LIM_W-1:0]  lim_hot;
    logic [LIM_W-1:0]  lim_cold;
    logic [THR_N-1:0]  flags;
    logic              ins_flag;
    logic              rem_flag;
    logic [1:0]        bp_sync;
    logic              bp_d;
    logic              bias_on;
    logic              int_act;
    logic              use_hot;
    logic              use_cold;
    logic              rcomp_ok;
    logic              hot_ok;
    logic              cold_ok;
  } gal_state_t;

endpackage

// File: rtl/gal_regs.sv
// Notes on behaviour
// - force bias bit keeps thermistor bias on
// - threshold enable lets violations raise the alert
// - insertion enable raises alert on insertion
// - removal enable raises alert on removal
// - restore loads termination from storage or capacity/10
// - termination current is 16 bits, current LSB
// - hotter than nominal uses hot coefficient
// - nominal temperature is signed bits 15:6
// - learning enables follow average temperature windows
`timescale 1ns/1ps
module gal_regs
#(
  parameter logic [15:0] FW_VERSION = gal_pkg::FW_VERSION
)
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output      logic                      sda_out,
  output      logic                      sda_oe,
  output      logic                      int_out,
  output      logic                      int_oe,
  input  wire logic                      sched_bias_req,
  input  wire logic [gal_pkg::THR_N-1:0] thr_viol,
  input  wire logic                      batt_present_pin,
  input  wire logic                      restore,
  input  wire logic                      otp_term_en,
  input  wire logic [15:0]               otp_term_val,
  input  wire logic [15:0]               design_capacity_setting,
  input  wire logic                      learn_valid,
  input  wire logic [15:0]               learn_cap,
  input  wire logic [15:0]               temperature,
  input  wire logic [15:0]               avg_temperature,
  output      logic                      thermistor_bias_on,
  output      logic                      gauge_interrupt,
  output      logic                      use_hot_coeff,
  output      logic                      use_cold_coeff,
  output      logic                      rcomp_learn_en,
  output      logic                      tco_hot_learn_en,
  output      logic                      tco_cold_learn_en
);

  gal_pkg::gal_state_t  st;
  gal_pkg::gal_state_t  next_st;
  gal_pkg::gal_regbus_t bus;
  logic [7:0]           rd_addr;
  logic [15:0]          rd_data;
  logic [15:0]          status_word;
  logic [15:0]          term_restore;
  logic signed [16:0]   nom_t;
  logic signed [16:0]   hot_t;
  logic signed [16:0]   cold_t;
  logic signed [16:0]   mid_hot;
  logic signed [16:0]   mid_cold;
  logic signed [16:0]   cur_t;
  logic signed [16:0]   avg_t;

  // =====================================================
  // serial host port
  gal_i2c_slave u_host
  (
    .clk     (clk),
    .rstn    (rstn),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .bus     (bus),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  assign sda_out            = 1'b0;
  assign int_out            = 1'b0;
  assign int_oe             = st.int_act;
  assign gauge_interrupt    = st.int_act;
  assign thermistor_bias_on = st.bias_on;
  assign use_hot_coeff      = st.use_hot;
  assign use_cold_coeff     = st.use_cold;
  assign rcomp_learn_en     = st.rcomp_ok;
  assign tco_hot_learn_en   = st.hot_ok;
  assign tco_cold_learn_en  = st.cold_ok;

  // =====================================================
  // temperatures in 1/256 degree steps
  always_comb
  begin
    nom_t    = 17'(signed'({st.nom_temp, gal_pkg::NOM_SPARE}));
    hot_t    = 17'(signed'({st.lim_hot, gal_pkg::LIM_FRAC}));
    cold_t   = 17'(signed'({st.lim_cold, gal_pkg::LIM_FRAC}));
    mid_hot  = (nom_t + hot_t) >>> 1;
    mid_cold = (nom_t + cold_t) >>> 1;
    cur_t    = 17'(signed'(temperature));
    avg_t    = 17'(signed'(avg_temperature));
  end

  assign term_restore = otp_term_en ? otp_term_val
                      : design_capacity_setting / gal_pkg::TERM_DIVISOR;

  always_comb
  begin
    status_word                      = gal_pkg::ZERO16;
    status_word[gal_pkg::THR_N-1:0]  = st.flags;
    status_word[gal_pkg::ST_INS_BIT] = st.ins_flag;
    status_word[gal_pkg::ST_REM_BIT] = st.rem_flag;
  end

  // =====================================================
  // read mux
  always_comb
  begin
    rd_data = gal_pkg::ZERO16;
    unique case (rd_addr)
      gal_pkg::STATUS_ADDR: rd_data = status_word;
      gal_pkg::CFG_ADDR:
      begin
        rd_data[gal_pkg::CFG_FORCE_BIT] = st.force_bias;
        rd_data[gal_pkg::CFG_THR_BIT]   = st.thr_en;
        rd_data[gal_pkg::CFG_INS_BIT]   = st.ins_en;
        rd_data[gal_pkg::CFG_REM_BIT]   = st.rem_en;
      end
      gal_pkg::TERM_ADDR:   rd_data = st.term_cur;
      gal_pkg::FWVER_ADDR:  rd_data = FW_VERSION;
      gal_pkg::CAPTAB_ADDR: rd_data = st.cap_tab;
      gal_pkg::FULL_ADDR:   rd_data = st.full_cap;
      gal_pkg::NOM_ADDR:    rd_data = {st.nom_temp, gal_pkg::NOM_SPARE};
      gal_pkg::LIM_ADDR:    rd_data = {st.lim_hot, st.lim_cold};
      default:              rd_data = gal_pkg::ZERO16;
    endcase
  end

  // =====================================================
  // next state
  always_comb
  begin
    next_st         = st;
    next_st.bp_sync = {st.bp_sync[0], batt_present_pin};
    next_st.bp_d    = st.bp_sync[1];
    if (bus.wr)
    begin
      unique case (bus.addr)
        gal_pkg::STATUS_ADDR:
        begin
          next_st.flags    = st.flags & ~bus.wdata[gal_pkg::THR_N-1:0];
          next_st.ins_flag = st.ins_flag & ~bus.wdata[gal_pkg::ST_INS_BIT];
          next_st.rem_flag = st.rem_flag & ~bus.wdata[gal_pkg::ST_REM_BIT];
        end
        gal_pkg::CFG_ADDR:
        begin
          next_st.force_bias = bus.wdata[gal_pkg::CFG_FORCE_BIT];
          next_st.thr_en     = bus.wdata[gal_pkg::CFG_THR_BIT];
          next_st.ins_en     = bus.wdata[gal_pkg::CFG_INS_BIT];
          next_st.rem_en     = bus.wdata[gal_pkg::CFG_REM_BIT];
        end
        gal_pkg::TERM_ADDR:   next_st.term_cur = bus.wdata;
        gal_pkg::CAPTAB_ADDR: next_st.cap_tab  = bus.wdata;
        gal_pkg::FULL_ADDR:   next_st.full_cap = bus.wdata;
        gal_pkg::NOM_ADDR:    next_st.nom_temp = bus.wdata[15:gal_pkg::NOM_LSB];
        gal_pkg::LIM_ADDR:
        begin
          next_st.lim_hot  = bus.wdata[15:8];
          next_st.lim_cold = bus.wdata[7:0];
        end
        default: ;
      endcase
    end
    // hardware updates come after the host clear so a set wins
    if (restore)
      next_st.term_cur = term_restore;
    if (learn_valid)
      next_st.full_cap = learn_cap;
    next_st.flags = next_st.flags | thr_viol;
    if (st.bp_sync[1] && !st.bp_d)
      next_st.ins_flag = 1'b1;
    if (!st.bp_sync[1] && st.bp_d)
      next_st.rem_flag = 1'b1;
    next_st.bias_on  = st.force_bias || sched_bias_req;
    next_st.int_act  = (st.thr_en && (st.flags != '0))
                    || (st.ins_en && st.ins_flag)
                    || (st.rem_en && st.rem_flag);
    next_st.use_hot  = cur_t > nom_t;
    next_st.use_cold = cur_t < nom_t;
    next_st.rcomp_ok = (avg_t > cold_t) && (avg_t < hot_t);
    next_st.hot_ok   = (avg_t > mid_hot) && (avg_t < hot_t);
    next_st.cold_ok  = (avg_t > cold_t) && (avg_t < mid_cold);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence pin_rise_s;
    !st.bp_sync[1] ##1 st.bp_sync[1];
  endsequence

  sequence pin_fall_s;
    st.bp_sync[1] ##1 !st.bp_sync[1];
  endsequence

  bias_force_a: assert property (st.force_bias |=> thermistor_bias_on)
    else $error("forced bias not on");

  thr_alert_a: assert property ((st.thr_en && st.flags != '0) |=> gauge_interrupt)
    else $error("threshold alert missing");

  flag_kept_a: assert property ((thr_viol != '0) |=>
    ((st.flags & $past(thr_viol)) == $past(thr_viol)))
    else $error("violation flag not set");

  ins_alert_a: assert property (pin_rise_s |=> st.ins_flag ##1 (!st.ins_en || int_oe))
    else $error("insertion alert missing");

  rem_alert_a: assert property (pin_fall_s |=> st.rem_flag ##1 (!st.rem_en || int_oe))
    else $error("removal alert missing");

  term_restore_a: assert property (restore |=>
    st.term_cur == ($past(otp_term_en) ? $past(otp_term_val)
                    : $past(design_capacity_setting) / gal_pkg::TERM_DIVISOR))
    else $error("termination restore wrong");

  term_write_a: assert property ((bus.wr && bus.addr == gal_pkg::TERM_ADDR && !restore)
    |=> st.term_cur == $past(bus.wdata))
    else $error("termination write lost");

  full_learn_a: assert property (learn_valid |=> st.full_cap == $past(learn_cap))
    else $error("learned capacity not taken");

  hot_coeff_a: assert property ((cur_t > nom_t) |=> use_hot_coeff && !use_cold_coeff)
    else $error("hot coefficient not chosen");

  nom_spare_a: assert property ((rd_addr == gal_pkg::NOM_ADDR) |-> rd_data[5:0] == '0)
    else $error("nominal spare bits not zero");

  lim_write_a: assert property ((bus.wr && bus.addr == gal_pkg::LIM_ADDR)
    |=> st.lim_hot == $past(bus.wdata[15:8]) && st.lim_cold == $past(bus.wdata[7:0]))
    else $error("limit write wrong");

  rcomp_win_a: assert property (((avg_t <= cold_t) || (avg_t >= hot_t))
    |=> !rcomp_learn_en)
    else $error("resistance learning outside window");

  // =====================================================
  // further checks

  bias_sched_a: assert property (sched_bias_req |=> thermistor_bias_on)
    else $error("scheduled bias not on");

  cfg_write_a: assert property ((bus.wr && bus.addr == gal_pkg::CFG_ADDR)
    |=> {st.force_bias, st.thr_en, st.ins_en, st.rem_en}
        == $past(bus.wdata[gal_pkg::CFG_FORCE_BIT:gal_pkg::CFG_REM_BIT]))
    else $error("config write wrong");

  thr_gate_a: assert property ((!st.thr_en && !st.ins_en && !st.rem_en)
    |=> !gauge_interrupt)
    else $error("alert without enable");

  flag_clear_a: assert property ((bus.wr && bus.addr == gal_pkg::STATUS_ADDR && thr_viol == '0)
    |=> (st.flags & $past(bus.wdata[gal_pkg::THR_N-1:0])) == '0)
    else $error("flag not cleared");

  int_quiet_a: assert property (((!st.thr_en || st.flags == '0)
    && (!st.ins_en || !st.ins_flag) && (!st.rem_en || !st.rem_flag)) |=> !int_oe)
    else $error("alert without cause");

  full_write_a: assert property ((bus.wr && bus.addr == gal_pkg::FULL_ADDR && !learn_valid)
    |=> st.full_cap == $past(bus.wdata))
    else $error("capacity write lost");

  cold_coeff_a: assert property ((cur_t < nom_t) |=> use_cold_coeff && !use_hot_coeff)
    else $error("cold coefficient not chosen");

  equal_coeff_a: assert property ((cur_t == nom_t) |=> !use_hot_coeff && !use_cold_coeff)
    else $error("coefficient chosen at nominal");

  nom_write_a: assert property ((bus.wr && bus.addr == gal_pkg::NOM_ADDR)
    |=> st.nom_temp == $past(bus.wdata[15:gal_pkg::NOM_LSB]))
    else $error("nominal write wrong");

  rcomp_in_a: assert property (((avg_t > cold_t) && (avg_t < hot_t)) |=> rcomp_learn_en)
    else $error("resistance learning missing");

  hot_win_a: assert property (((avg_t <= mid_hot) || (avg_t >= hot_t))
    |=> !tco_hot_learn_en)
    else $error("hot learning outside window");

  cold_win_a: assert property (((avg_t <= cold_t) || (avg_t >= mid_cold))
    |=> !tco_cold_learn_en)
    else $error("cold learning outside window");

endmodule

// File: testbench/gal_regs_tb.sv
`timescale 1ns/1ps
module gal_regs_tb;
  // ==========================================
  // signals
  logic        clk, rstn, scl_m, sda_m, sched_bias_req, batt_present_pin;
  logic        restore, otp_term_en, learn_valid;
  logic [5:0]  thr_viol;
  logic [15:0] otp_term_val, design_capacity_setting, learn_cap, temperature, avg_temperature;
  logic        sda_out, sda_oe, int_out, int_oe, thermistor_bias_on, gauge_interrupt;
  logic        use_hot_coeff, use_cold_coeff, rcomp_learn_en, tco_hot_learn_en;
  logic        tco_cold_learn_en;
  logic        sda_line;
  int          err_total;
  int          cmp_count;
  int          cyc;
  logic [15:0] avg_tab [5] = '{16'h1900, 16'h2200, 16'h0f00, 16'h2900, 16'h0900};
  logic [15:0] win_tab [5] = '{16'h0004, 16'h0006, 16'h0005, 16'h0000, 16'h0000};

  // open drain data line: master releases high, device pulls low
  assign sda_line = sda_m & ~sda_oe;

  gal_regs dut
  (
    .clk(clk), .rstn(rstn), .scl_in(scl_m), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe), .sched_bias_req(sched_bias_req),
    .thr_viol(thr_viol), .batt_present_pin(batt_present_pin), .restore(restore),
    .otp_term_en(otp_term_en), .otp_term_val(otp_term_val),
    .design_capacity_setting(design_capacity_setting), .learn_valid(learn_valid),
    .learn_cap(learn_cap), .temperature(temperature), .avg_temperature(avg_temperature),
    .thermistor_bias_on(thermistor_bias_on), .gauge_interrupt(gauge_interrupt),
    .use_hot_coeff(use_hot_coeff), .use_cold_coeff(use_cold_coeff),
    .rcomp_learn_en(rcomp_learn_en), .tco_hot_learn_en(tco_hot_learn_en),
    .tco_cold_learn_en(tco_cold_learn_en)
  );

  always #2 clk = ~clk;

  // ==========================================
  // checking and verdict
  task automatic give_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      give_verdict();
    end
  end

  // ==========================================
  // two-wire serial master
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic put_bit(input logic b);
    settle(2);
    sda_m = b;
    settle(6);
    scl_m = 1'b1;
    settle(6);
    scl_m = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    settle(2);
    sda_m = 1'b1;
    settle(6);
    scl_m = 1'b1;
    settle(6);
    b = sda_line;
    scl_m = 1'b0;
  endtask

  task automatic start_cond;
    settle(2);
    sda_m = 1'b1;
    settle(6);
    scl_m = 1'b1;
    settle(6);
    sda_m = 1'b0;
    settle(6);
    scl_m = 1'b0;
  endtask

  task automatic stop_cond;
    settle(2);
    sda_m = 1'b0;
    settle(6);
    scl_m = 1'b1;
    settle(6);
    sda_m = 1'b1;
    settle(6);
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(a);
    chk1(a, 1'b0);
  endtask

  task automatic refused_chk(input logic [7:0] b);
    logic a;
    start_cond();
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(a);
    stop_cond();
    chk1(a, 1'b1);
  endtask

  task automatic recv_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(last);
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
    start_cond();
    send_byte({gal_pkg::DEV_ADDR, 1'b0});
    send_byte(addr);
    send_byte(data[7:0]);
    send_byte(data[15:8]);
    stop_cond();
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    start_cond();
    send_byte({gal_pkg::DEV_ADDR, 1'b0});
    send_byte(addr);
    start_cond();
    send_byte({gal_pkg::DEV_ADDR, 1'b1});
    recv_byte(d[7:0], 1'b0);
    recv_byte(d[15:8], 1'b1);
    stop_cond();
    chk16(d, exp);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    settle(1);
    s = 1'b0;
    settle(2);
  endtask

  // ==========================================
  // tests
  initial
  begin
    {clk, rstn, scl_m, sda_m} = 4'b0011;
    {sched_bias_req, batt_present_pin, restore, otp_term_en, learn_valid} = 5'h00;
    {thr_viol, otp_term_val, design_capacity_setting} = '0;
    {learn_cap, temperature, avg_temperature} = '0;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    settle(5);
    rstn = 1'b1;
    settle(6);
    chk1(sda_out, 1'b0);
    rd_chk(gal_pkg::CFG_ADDR, 16'h0000);
    rd_chk(gal_pkg::FWVER_ADDR, gal_pkg::FW_VERSION);
    reg_write(gal_pkg::FWVER_ADDR, 16'h1234);
    rd_chk(gal_pkg::FWVER_ADDR, gal_pkg::FW_VERSION);
    rd_chk(8'h30, 16'h0000);
    refused_chk(8'h5a);
    reg_write(gal_pkg::CFG_ADDR, 16'h00ff);
    rd_chk(gal_pkg::CFG_ADDR, 16'h000f);
    chk1(gauge_interrupt, 1'b0);
    reg_write(gal_pkg::CFG_ADDR, 16'h0008);
    chk1(thermistor_bias_on, 1'b1);
    reg_write(gal_pkg::CFG_ADDR, 16'h0000);
    chk1(thermistor_bias_on, 1'b0);
    sched_bias_req = 1'b1;
    settle(2);
    chk1(thermistor_bias_on, 1'b1);
    sched_bias_req = 1'b0;
    thr_viol = 6'h24;
    settle(4);
    chk1(int_oe, 1'b0);
    rd_chk(gal_pkg::STATUS_ADDR, 16'h0024);
    thr_viol = 6'h00;
    reg_write(gal_pkg::CFG_ADDR, 16'h0004);
    chk1(gauge_interrupt, 1'b1);
    chk1(int_oe, 1'b1);
    chk1(int_out, 1'b0);
    reg_write(gal_pkg::STATUS_ADDR, 16'h00ff);
    chk1(gauge_interrupt, 1'b0);
    reg_write(gal_pkg::CFG_ADDR, 16'h0002);
    batt_present_pin = 1'b1;
    settle(8);
    chk1(gauge_interrupt, 1'b1);
    reg_write(gal_pkg::STATUS_ADDR, 16'h00ff);
    chk1(gauge_interrupt, 1'b0);
    reg_write(gal_pkg::CFG_ADDR, 16'h0001);
    batt_present_pin = 1'b0;
    settle(8);
    chk1(int_oe, 1'b1);
    rd_chk(gal_pkg::STATUS_ADDR, 16'h0080);
    reg_write(gal_pkg::STATUS_ADDR, 16'h00ff);
    reg_write(gal_pkg::TERM_ADDR, 16'hfedc);
    rd_chk(gal_pkg::TERM_ADDR, 16'hfedc);
    {otp_term_en, otp_term_val, design_capacity_setting} = {1'b1, 16'h0123, 16'h1391};
    pulse(restore);
    rd_chk(gal_pkg::TERM_ADDR, 16'h0123);
    otp_term_en = 1'b0;
    pulse(restore);
    rd_chk(gal_pkg::TERM_ADDR, 16'h01f4);
    reg_write(gal_pkg::CAPTAB_ADDR, 16'h8421);
    rd_chk(gal_pkg::CAPTAB_ADDR, 16'h8421);
    reg_write(gal_pkg::FULL_ADDR, 16'h1111);
    learn_cap = 16'h2bcd;
    pulse(learn_valid);
    rd_chk(gal_pkg::FULL_ADDR, 16'h2bcd);
    reg_write(gal_pkg::NOM_ADDR, 16'h193f);
    rd_chk(gal_pkg::NOM_ADDR, 16'h1900);
    temperature = 16'h1a00;
    settle(2);
    chk16({14'h0, use_hot_coeff, use_cold_coeff}, 16'h0002);
    temperature = 16'h1800;
    settle(2);
    chk16({14'h0, use_hot_coeff, use_cold_coeff}, 16'h0001);
    reg_write(gal_pkg::LIM_ADDR, 16'h280a);
    rd_chk(gal_pkg::LIM_ADDR, 16'h280a);
    // windows: cold 10, hot 40, nominal 25, midpoints 32.5 and 17.5 degrees
    foreach (avg_tab[i])
    begin
      avg_temperature = avg_tab[i];
      settle(3);
      chk16({13'h0, rcomp_learn_en, tco_hot_learn_en, tco_cold_learn_en}, win_tab[i]);
    end
    // reset again in mid-run: registers return to zero
    rstn = 1'b0;
    settle(5);
    rstn = 1'b1;
    settle(6);
    chk1(gauge_interrupt, 1'b0);
    rd_chk(gal_pkg::LIM_ADDR, 16'h0000);
    rd_chk(gal_pkg::CFG_ADDR, 16'h0000);
    give_verdict();
  end
endmodule
